/* File: logic/adc_channel_results.sv */
// Channel disable register and current result registers of the monitoring converter
// Behaviour
// (R1) Set disable bit skips that channel's conversion; cleared bit lets it convert.
// (R2) Disable register bit 1 ignores writes and reads zero.
// (R3) Register reset zeroes all fields; watchdog expiry leaves them alone.
// (R4) Input current result is 16-bit two's complement, bit 15 sign.
// (R5) Input current high byte at 17h, bits 6..0 weigh 16384 to 256 mA.
// (R6) Input current low byte at 18h, one count is 1 mA.
// (R7) Input current positive into supply pin, negative out; nominal 0 to 4 A.
// (R8) Charge current high byte at 19h holds result bits 14..8, unsigned.
// (R9) Charge current high byte bit 7 always reads zero.
// (R10) Charge current low byte at 1Ah, one count is 1 mA.
// (R11) Nothing converts while master enable is clear, its default.
// (R12) Rate bit clear repeats conversions; set does one pass.
// (R13) Result pair updates only when its enabled channel completes conversion.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_results #(
    parameter int CONV_CYCLES = conv_results_pkg::CONV_CYCLES
) (
    // Clock and resets
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire logic                        reg_reset,
    input  wire logic                        watchdog_expired,
    // Register port from the serial host interface
    input  wire conv_results_pkg::reg_req_s  req,
    input  wire logic                        req_valid,
    output logic [7:0]                       rdata_q,
    // Analogue side samples
    input  wire logic [15:0]                 input_current_sample,
    input  wire logic [15:0]                 charge_current_sample,
    output logic                             input_current_channel_off,
    output logic                             charge_current_channel_off,
    output logic                             input_voltage_channel_off,
    output logic                             battery_voltage_channel_off,
    output logic                             system_voltage_channel_off,
    output logic                             thermistor_channel_off,
    output logic                             die_temp_channel_off,
    output logic                             converting,
    output logic                             one_shot_done
);
    logic        clr;
    logic [7:0]  ch_disable_q;
    logic [7:0]  ctrl_q;
    logic [15:0] input_current_result;
    logic [15:0] charge_current_result;
    logic [15:0] sample_mux;
    logic [2:0]  cur_ch;
    conv_results_pkg::conv_result_s res;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Watchdog expiry is deliberately not part of the clear
    assign clr = srst || reg_reset; // see (R3)

    always_ff @(posedge mclk) begin
        if (clr) begin
            ch_disable_q <= conv_results_pkg::RESET_ZERO; // see (R3)
        end else if (req_valid && req.wr && hit(req.addr, conv_results_pkg::ADDR_CH_DISABLE)) begin
            ch_disable_q <= req.wdata & conv_results_pkg::CH_DISABLE_MASK; // see (R2)
        end
    end

    // Converter control: enable and rate; the enable also drops on watchdog expiry
    always_ff @(posedge mclk) begin
        if (clr) begin
            ctrl_q <= conv_results_pkg::CTRL_RESET; // see (R11)
        end else begin
            if (req_valid && req.wr && hit(req.addr, conv_results_pkg::ADDR_ADC_CTRL)) begin
                ctrl_q <= req.wdata & conv_results_pkg::CTRL_WRITE_MASK;
            end else if (one_shot_done && ctrl_q[conv_results_pkg::CTRL_RATE_BIT]) begin
                ctrl_q[conv_results_pkg::CTRL_EN_BIT] <= 1'b0; // see (R12)
            end
            if (watchdog_expired) begin
                ctrl_q[conv_results_pkg::CTRL_EN_BIT] <= 1'b0;
            end
        end
    end

    assign input_current_channel_off   = ch_disable_q[conv_results_pkg::CH_IIN];
    assign charge_current_channel_off  = ch_disable_q[conv_results_pkg::CH_ICHG];
    assign input_voltage_channel_off   = ch_disable_q[conv_results_pkg::CH_VBUS];
    assign battery_voltage_channel_off = ch_disable_q[conv_results_pkg::CH_VBAT];
    assign system_voltage_channel_off  = ch_disable_q[conv_results_pkg::CH_VSYS];
    assign thermistor_channel_off      = ch_disable_q[conv_results_pkg::CH_TS];
    assign die_temp_channel_off        = ch_disable_q[conv_results_pkg::CH_TDIE];
    assign converting                  = ctrl_q[conv_results_pkg::CTRL_EN_BIT]; // see (R11)

    // Only the two current channels have samples wired here
    always_comb begin
        case (cur_ch)
            3'(conv_results_pkg::CH_IIN):  sample_mux = input_current_sample;
            3'(conv_results_pkg::CH_ICHG): sample_mux = charge_current_sample;
            default:                       sample_mux = '0;
        endcase
    end

    conv_sequencer #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_seq (
        .mclk          (mclk),
        .srst          (clr),
        .conv_enable   (converting),
        .one_shot      (ctrl_q[conv_results_pkg::CTRL_RATE_BIT]), // see (R12)
        .channel_off   (ch_disable_q | ~conv_results_pkg::CH_DISABLE_MASK),
        .one_shot_done (one_shot_done),
        .slot_ch       (cur_ch),
        .sample        (sample_mux),
        .result        (res)
    );

    // Sign kept in bit 15: positive into the supply pin, negative out of it
    result_pair #(
        .KEEP_MASK (16'hFFFF)
    ) u_iin (
        .mclk   (mclk),
        .srst   (clr),
        .load   (res.done && res.ch == 3'(conv_results_pkg::CH_IIN)), // see (R4) (R7) (R13)
        .value  (res.value),
        .held_q (input_current_result)
    );

    // Charge current is unsigned, so bit 15 is forced clear
    result_pair #(
        .KEEP_MASK (16'h7FFF)
    ) u_ichg (
        .mclk   (mclk),
        .srst   (clr),
        .load   (res.done && res.ch == 3'(conv_results_pkg::CH_ICHG)), // see (R8) (R9) (R13)
        .value  (res.value),
        .held_q (charge_current_result)
    );

    // Read data registered one cycle after the request
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_q <= conv_results_pkg::RESET_ZERO;
        end else if (req_valid && !req.wr) begin
            case (req.addr)
                conv_results_pkg::ADDR_ADC_CTRL:   rdata_q <= ctrl_q;
                conv_results_pkg::ADDR_CH_DISABLE: begin
                    rdata_q <= ch_disable_q & conv_results_pkg::CH_DISABLE_MASK; // see (R2)
                end
                conv_results_pkg::ADDR_IIN_HIGH:   rdata_q <= input_current_result[15:8]; // see (R5)
                conv_results_pkg::ADDR_IIN_LOW:    rdata_q <= input_current_result[7:0]; // see (R6)
                conv_results_pkg::ADDR_ICHG_HIGH:  rdata_q <= {1'b0, charge_current_result[14:8]}; // see (R8) (R9)
                conv_results_pkg::ADDR_ICHG_LOW:   rdata_q <= charge_current_result[7:0]; // see (R10)
                default:                           rdata_q <= conv_results_pkg::RESET_ZERO;
            endcase
        end
    end

    chk_reserved_reads_zero: assert property (@(posedge mclk) disable iff (srst)
        !ch_disable_q[conv_results_pkg::CH_RESERVED]) else $error("reserved disable bit set"); // see (R2)
    chk_ichg_no_sign: assert property (@(posedge mclk) disable iff (srst)
        req_valid && !req.wr && req.addr == conv_results_pkg::ADDR_ICHG_HIGH |=> !rdata_q[7])
        else $error("charge high byte bit 7 set"); // see (R9)
    chk_iin_high_read: assert property (@(posedge mclk) disable iff (srst)
        req_valid && !req.wr && req.addr == conv_results_pkg::ADDR_IIN_HIGH
        |=> rdata_q == $past(input_current_result[15:8]))
        else $error("input current high byte wrong"); // see (R5)
    chk_iin_low_read: assert property (@(posedge mclk) disable iff (srst)
        req_valid && !req.wr && req.addr == conv_results_pkg::ADDR_IIN_LOW
        |=> rdata_q == $past(input_current_result[7:0]))
        else $error("input current low byte wrong"); // see (R6)
    chk_ichg_low_read: assert property (@(posedge mclk) disable iff (srst)
        req_valid && !req.wr && req.addr == conv_results_pkg::ADDR_ICHG_LOW
        |=> rdata_q == $past(charge_current_result[7:0]))
        else $error("charge low byte wrong"); // see (R10)
    chk_reset_clears: assert property (@(posedge mclk)
        reg_reset |=> ch_disable_q == 8'h00 && input_current_result == 16'h0000 && charge_current_result == 16'h0000)
        else $error("register reset left a field set"); // see (R3)
    chk_watchdog_keeps: assert property (@(posedge mclk) disable iff (clr)
        watchdog_expired && !(req_valid && req.wr) |=> $stable(ch_disable_q))
        else $error("watchdog altered disable register"); // see (R3)
    chk_disabled_holds: assert property (@(posedge mclk) disable iff (clr)
        // A completion launched just before the disable write may still land, so look two cycles back
        ch_disable_q[conv_results_pkg::CH_IIN] && $past(ch_disable_q[conv_results_pkg::CH_IIN])
        && $past(ch_disable_q[conv_results_pkg::CH_IIN], 2)
        |-> $stable(input_current_result))
        else $error("disabled channel result changed"); // see (R1) (R13)
    chk_off_no_update: assert property (@(posedge mclk) disable iff (clr)
        !converting |=> !res.done) else $error("result while converter off"); // see (R11)
    chk_iin_sign_kept: assert property (@(posedge mclk) disable iff (clr)
        res.done && res.ch == 3'(conv_results_pkg::CH_IIN) |=> input_current_result == $past(res.value))
        else $error("input current value not taken whole"); // see (R4) (R7)
endmodule : adc_channel_results
`default_nettype wire

/* File: logic/conv_results_pkg.sv */
// Shared constants and carriers for the converter channel and result registers
package conv_results_pkg;
    localparam logic [7:0] ADDR_ADC_CTRL    = 8'h15;
    localparam logic [7:0] ADDR_CH_DISABLE  = 8'h16;
    localparam logic [7:0] ADDR_IIN_HIGH    = 8'h17;
    localparam logic [7:0] ADDR_IIN_LOW     = 8'h18;
    localparam logic [7:0] ADDR_ICHG_HIGH   = 8'h19;
    localparam logic [7:0] ADDR_ICHG_LOW    = 8'h1A;
    localparam logic [7:0] RESET_ZERO       = 8'h00;
    localparam logic [7:0] CH_DISABLE_MASK  = 8'hFD;
    localparam logic [7:0] CTRL_WRITE_MASK  = 8'hF0;
    localparam logic [7:0] CTRL_RESET       = 8'h30;
    localparam int         CTRL_EN_BIT      = 7;
    localparam int         CTRL_RATE_BIT    = 6;
    localparam int         NUM_CH           = 8;
    localparam int         CH_TDIE          = 0;
    localparam int         CH_RESERVED      = 1;
    localparam int         CH_TS            = 2;
    localparam int         CH_VSYS          = 3;
    localparam int         CH_VBAT          = 4;
    localparam int         CH_VBUS          = 5;
    localparam int         CH_ICHG          = 6;
    localparam int         CH_IIN           = 7;
    localparam int         CONV_TIME_US     = 2;
    localparam int         CLK_MHZ          = 10;
    localparam int         CONV_CYCLES      = CONV_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        done;
        logic [2:0]  ch;
        logic [15:0] value;
    } conv_result_s;
endpackage : conv_results_pkg

/* File: logic/conv_sequencer.sv */
// Walks all channel slots and reports one completed conversion per enabled slot
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer #(
    parameter int CONV_CYCLES = conv_results_pkg::CONV_CYCLES
) (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // Control
    input  wire logic                          conv_enable,
    input  wire logic                          one_shot,
    input  wire logic [7:0]                    channel_off,
    output logic                               one_shot_done,
    output logic [2:0]                         slot_ch,
    // Analogue side sample
    input  wire logic [15:0]                   sample,
    output conv_results_pkg::conv_result_s     result
);
    typedef enum logic [1:0] {IDLE, CONVERT, DONE_PASS} seq_e;
    seq_e        state_q;
    logic [2:0]  ch_q;
    logic [15:0] tick_q;
    logic        slot_end;

    assign slot_end      = (tick_q == 16'(CONV_CYCLES - 1));
    assign one_shot_done = (state_q == DONE_PASS);
    assign slot_ch       = ch_q;

    always_ff @(posedge mclk) begin
        if (srst || !conv_enable) begin
            state_q <= IDLE;
            // Scan starts at the top slot so a one-shot pass covers every channel
            ch_q    <= 3'(conv_results_pkg::NUM_CH - 1);
            tick_q  <= '0;
        end else begin
            case (state_q)
                IDLE: begin
                    state_q <= CONVERT;
                end
                CONVERT: begin
                    tick_q <= slot_end ? '0 : tick_q + 16'h0001;
                    if (slot_end) begin
                        ch_q <= ch_q - 3'h1;
                        if (ch_q == 3'h0 && one_shot) begin
                            state_q <= DONE_PASS;
                        end
                    end
                end
                DONE_PASS: begin
                    state_q <= DONE_PASS;
                end
                default: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end

    // Disabled or reserved slots pass without producing a result
    always_ff @(posedge mclk) begin
        if (srst) begin
            result <= '0;
        end else begin
            result.done  <= conv_enable && state_q == CONVERT && slot_end && !channel_off[ch_q]; // see (R1)
            result.ch    <= ch_q;
            result.value <= sample;
        end
    end
endmodule : conv_sequencer
`default_nettype wire

/* File: logic/result_pair.sv */
// Holds one two-byte conversion result, updated only on its channel's completion
`timescale 1ns/1ps
`default_nettype none
module result_pair #(
    parameter logic [15:0] KEEP_MASK = 16'hFFFF
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Update
    input  wire logic        load,
    input  wire logic [15:0] value,
    // Held value
    output logic [15:0]      held_q
);
    always_ff @(posedge mclk) begin
        if (srst) begin
            held_q <= '0; // see (R3)
        end else if (load) begin
            held_q <= value & KEEP_MASK; // see (R13)
        end
    end
endmodule : result_pair
`default_nettype wire

/* File: verification/host_regs_model.sv */
// Host side model: issues register reads and writes on the device register port
`timescale 1ns/1ps
`default_nettype none
module host_regs_model (
    // Clock
    input  wire logic                       mclk,
    // Register port
    output var conv_results_pkg::reg_req_s  req,
    output var logic                        req_valid,
    input  wire logic [7:0]                 rdata_q
);
    initial begin
        req       = '0;
        req_valid = 1'b0;
    end

    // Request held until its sampling edge; data taken after that edge has settled
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] data);
        @(posedge mclk);
        req       <= '{wr: wr, addr: addr, wdata: wdata};
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        @(negedge mclk);
        data = rdata_q;
    endtask : access
endmodule : host_regs_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the converter channel and result registers
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CONV_CYC = 4;
    // Longer than a full scan of eight slots
    localparam int SETTLE   = 80;
    logic                       mclk = 1'b0;
    logic                       srst = 1'b1;
    logic                       reg_reset = 1'b0;
    logic                       watchdog_expired = 1'b0;
    conv_results_pkg::reg_req_s req;
    logic                       req_valid;
    logic [7:0]                 rdata_q;
    logic [15:0]                ic_smp = 16'h0000;
    logic [15:0]                cc_smp = 16'h0000;
    logic [6:0]                 ch_off;
    logic                       converting;
    logic                       one_shot_done;
    int                         err_count = 0;
    int                         total_checks = 0;

    always #50 mclk = ~mclk;

    adc_channel_results #(.CONV_CYCLES(CONV_CYC)) i_adc_channel_results (
        .mclk(mclk), .srst(srst), .reg_reset(reg_reset), .watchdog_expired(watchdog_expired),
        .req(req), .req_valid(req_valid), .rdata_q(rdata_q),
        .input_current_sample(ic_smp), .charge_current_sample(cc_smp),
        .input_current_channel_off(ch_off[6]), .charge_current_channel_off(ch_off[5]),
        .input_voltage_channel_off(ch_off[4]), .battery_voltage_channel_off(ch_off[3]),
        .system_voltage_channel_off(ch_off[2]), .thermistor_channel_off(ch_off[1]),
        .die_temp_channel_off(ch_off[0]), .converting(converting), .one_shot_done(one_shot_done));

    host_regs_model i_host_regs_model (.mclk(mclk), .req(req), .req_valid(req_valid), .rdata_q(rdata_q));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        i_host_regs_model.access(1'b0, addr, 8'h00, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rd_chk

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        i_host_regs_model.access(1'b1, addr, data, d);
    endtask : wr

    task automatic settle();
        repeat (SETTLE) @(posedge mclk);
    endtask : settle

    task automatic t_reset_values();
        rd_chk(conv_results_pkg::ADDR_ADC_CTRL, 8'h30);
        for (int a = 16'h16; a <= 16'h1A; a++) rd_chk(a[7:0], 8'h00);
        rd_chk(8'h20, 8'h00);
        $display("reset values done");
    endtask : t_reset_values

    task automatic t_disable_bits();
        wr(conv_results_pkg::ADDR_CH_DISABLE, 8'hFF);
        rd_chk(conv_results_pkg::ADDR_CH_DISABLE, 8'hFD);
        chk({9'h000, ch_off}, 16'h007F);
        wr(conv_results_pkg::ADDR_CH_DISABLE, 8'h00);
        chk({9'h000, ch_off}, 16'h0000);
        $display("disable bits done");
    endtask : t_disable_bits

    task automatic t_continuous();
        @(posedge mclk);
        ic_smp <= 16'hF830;
        cc_smp <= 16'hFFFF;
        wr(conv_results_pkg::ADDR_ADC_CTRL, 8'h80);
        settle();
        chk({15'h0000, converting}, 16'h0001);
        rd_chk(conv_results_pkg::ADDR_IIN_HIGH, 8'hF8);
        rd_chk(conv_results_pkg::ADDR_IIN_LOW, 8'h30);
        rd_chk(conv_results_pkg::ADDR_ICHG_HIGH, 8'h7F);
        rd_chk(conv_results_pkg::ADDR_ICHG_LOW, 8'hFF);
        $display("continuous done");
    endtask : t_continuous

    task automatic t_skip_channel();
        wr(conv_results_pkg::ADDR_CH_DISABLE, 8'hC0);
        chk({9'h000, ch_off}, 16'h0060);
        @(posedge mclk);
        ic_smp <= 16'h0FA0;
        cc_smp <= 16'h1234;
        settle();
        rd_chk(conv_results_pkg::ADDR_IIN_HIGH, 8'hF8);
        rd_chk(conv_results_pkg::ADDR_ICHG_LOW, 8'hFF);
        wr(conv_results_pkg::ADDR_CH_DISABLE, 8'h00);
        settle();
        rd_chk(conv_results_pkg::ADDR_IIN_HIGH, 8'h0F);
        rd_chk(conv_results_pkg::ADDR_IIN_LOW, 8'hA0);
        rd_chk(conv_results_pkg::ADDR_ICHG_HIGH, 8'h12);
        rd_chk(conv_results_pkg::ADDR_ICHG_LOW, 8'h34);
        $display("skip channel done");
    endtask : t_skip_channel

    task automatic t_watchdog();
        wr(conv_results_pkg::ADDR_CH_DISABLE, 8'h5C);
        @(posedge mclk) watchdog_expired <= 1'b1;
        @(posedge mclk) watchdog_expired <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({15'h0000, converting}, 16'h0000);
        rd_chk(conv_results_pkg::ADDR_CH_DISABLE, 8'h5C);
        @(posedge mclk);
        ic_smp <= 16'h0001;
        cc_smp <= 16'h0002;
        settle();
        rd_chk(conv_results_pkg::ADDR_IIN_HIGH, 8'h0F);
        rd_chk(conv_results_pkg::ADDR_ICHG_LOW, 8'h34);
        $display("watchdog done");
    endtask : t_watchdog

    task automatic t_one_shot();
        wr(conv_results_pkg::ADDR_CH_DISABLE, 8'h00);
        wr(conv_results_pkg::ADDR_ADC_CTRL, 8'hC0);
        // Pass flag stands only until one cycle after the enable drops, so poll every cycle
        for (int i = 0; i < 200 && one_shot_done !== 1'b1; i++) @(negedge mclk);
        chk({15'h0000, one_shot_done}, 16'h0001);
        repeat (3) @(posedge mclk);
        chk({15'h0000, converting}, 16'h0000);
        @(posedge mclk);
        ic_smp <= 16'h0100;
        settle();
        rd_chk(conv_results_pkg::ADDR_IIN_LOW, 8'h01);
        rd_chk(conv_results_pkg::ADDR_ICHG_LOW, 8'h02);
        $display("one shot done");
    endtask : t_one_shot

    task automatic t_reg_reset();
        wr(conv_results_pkg::ADDR_IIN_LOW, 8'hAA);
        rd_chk(conv_results_pkg::ADDR_IIN_LOW, 8'h01);
        wr(conv_results_pkg::ADDR_CH_DISABLE, 8'hFF);
        @(posedge mclk) reg_reset <= 1'b1;
        @(posedge mclk) reg_reset <= 1'b0;
        for (int a = 16'h16; a <= 16'h1A; a++) rd_chk(a[7:0], 8'h00);
        rd_chk(conv_results_pkg::ADDR_ADC_CTRL, 8'h30);
        $display("register reset done");
    endtask : t_reg_reset

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_reset_values();
        t_disable_bits();
        t_continuous();
        t_skip_channel();
        t_watchdog();
        t_one_shot();
        t_reg_reset();
        report_and_stop();
    end

    // Whole sequence needs about 530 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
